// ### inc/addr_rx_defs.svh
/*
  Holds the constants shared by the address-detect receiver and the remote
  transmitter: register field positions, the transmit status reset value and timing counts.
  Assumes it is included by bare name from the design files.
*/
`ifndef ADDR_RX_DEFS_SVH
`define ADDR_RX_DEFS_SVH

// ----------------------------------------------------------------------
// Receive status register fields
// ----------------------------------------------------------------------
`define RXS_PORT_EN    7
`define RXS_NINE_SEL   6
`define RXS_SINGLE_EN  5
`define RXS_CONT_EN    4
`define RXS_ADDR_EN    3
`define RXS_FRAME_ERR  2
`define RXS_OVERRUN    1
`define RXS_NINTH      0

// ----------------------------------------------------------------------
// Transmit status register fields and reset value
// ----------------------------------------------------------------------
`define TXS_CLK_SRC    7
`define TXS_NINE_SEL   6
`define TXS_TX_EN      5
`define TXS_SYNC_MODE  4
`define TXS_BREAK_REQ  3
`define TXS_HIGH_SPEED 2
`define TXS_SHIFT_EMPTY 1
`define TXS_NINTH      0
`define TXS_RESET      8'h02

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OVERSAMPLE     5'h10
`define HALF_BIT       5'h08
`define LAST_TICK      4'hF
`define PRESCALE_SLOW  3'h4
`define PRESCALE_FAST  3'h1
`define FIFO_DEPTH     2'h2
`define BITS_EIGHT     4'h8
`define BITS_NINE      4'h9

`endif

// ### inc/addr_rx_pkg.sv
/*
  Holds the types shared by both ends of the serial link.
  Assumes the defs header supplies every numeric constant.
*/
package addr_rx_pkg;

  // Receiver sequence
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_type;

  // Transmitter sequence
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP
  } tx_state_type;

  // One stored character: framing error and nine data bits
  typedef struct packed {
    logic       frame_err;
    logic [8:0] data;
  } rx_entry_type;

endpackage

// ### inc/serial_link_if.sv
/*
  Holds the one-wire asynchronous link between the remote transmitter and
  the address-detect receiver.
  Assumes the line idles high and is driven by the remote end only.
*/
`timescale 1ns/1ps
interface serial_link_if;
  logic serial_line; // Idle high, start bit low

  // Receiving device samples the line
  modport device (input serial_line);
  // Remote transmitter drives the line
  modport remote (output serial_line);
endinterface // serial_link_if

// ### hw/remote_async_transmitter.sv
/*
  Holds the remote asynchronous transmitter: start bit, eight or nine data
  bits LSB first, one stop bit.
  Assumes the user holds tx_valid and tx_data until tx_ready is seen.
*/
`timescale 1ns/1ps
`include "addr_rx_defs.svh"
module remote_async_transmitter (
  input wire logic clk_sys,
  input wire logic rst_n,
  serial_link_if.remote link,
  input wire logic tx_valid,
  input wire logic [8:0] tx_data,
  input wire logic nine_bit,
  input wire logic [15:0] bit_cycles,
  output logic tx_ready
);

  addr_rx_pkg::tx_state_type state_q; // Sequence state
  logic [15:0] cyc_q; // Cycles left in current bit
  logic [3:0] bit_q; // Data bits sent
  logic [8:0] shift_q; // Outgoing bits
  logic line_q; // Line level

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  // Walks start, data and stop bits, each bit_cycles long
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= addr_rx_pkg::TX_IDLE;
      cyc_q <= 16'h0000;
      bit_q <= 4'h0;
      shift_q <= 9'h000;
      line_q <= 1'b1;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= 1'b0;
      case (state_q)
        addr_rx_pkg::TX_IDLE: begin
          line_q <= 1'b1;
          if (tx_valid && !tx_ready) begin
            // Accept character, drive start bit
            shift_q <= tx_data;
            tx_ready <= 1'b1;
            line_q <= 1'b0;
            cyc_q <= bit_cycles;
            state_q <= addr_rx_pkg::TX_START;
          end
        end
        addr_rx_pkg::TX_START: begin
          if (cyc_q <= 16'h0001) begin
            line_q <= shift_q[0];
            shift_q <= {1'b0, shift_q[8:1]};
            bit_q <= 4'h1;
            cyc_q <= bit_cycles;
            state_q <= addr_rx_pkg::TX_DATA;
          end else begin
            cyc_q <= cyc_q - 16'h0001;
          end
        end
        addr_rx_pkg::TX_DATA: begin
          if (cyc_q <= 16'h0001) begin
            cyc_q <= bit_cycles;
            if (bit_q == (nine_bit ? `BITS_NINE : `BITS_EIGHT)) begin
              // Stop bit
              line_q <= 1'b1;
              state_q <= addr_rx_pkg::TX_STOP;
            end else begin
              line_q <= shift_q[0];
              shift_q <= {1'b0, shift_q[8:1]};
              bit_q <= bit_q + 4'h1;
            end
          end else begin
            cyc_q <= cyc_q - 16'h0001;
          end
        end
        addr_rx_pkg::TX_STOP: begin
          if (cyc_q <= 16'h0001) begin
            state_q <= addr_rx_pkg::TX_IDLE;
          end else begin
            cyc_q <= cyc_q - 16'h0001;
          end
        end
        default: state_q <= addr_rx_pkg::TX_IDLE;
      endcase
    end
  end

  assign link.serial_line = line_q;

endmodule // remote_async_transmitter

// ### hw/async_receiver_address_detect.sv
/*
  Holds the asynchronous receiver with nine-bit address detection, its
  two-character FIFO, its receive status and the transmit status register.
  Assumes control bits come from software as plain levels and that the
  serial line arrives unsynchronised.
*/
`timescale 1ns/1ps
`include "addr_rx_defs.svh"
// Overview of operation
// - Filter enable turns on address detection
// - Nine-bit filter keeps only ninth-bit-set characters
// - Software clears filter before next stop bit
// - Software sets filter again at message end
// - Pending flag on FIFO load, interrupt if enabled
// - Clearing continuous receive clears overrun
// - Software programs baud, enables, then receive
// - Filtered characters always read ninth bit one
// - Software reads status before data
// - Clock source master/slave only in synchronous
// - Transmit width nine or eight bits
// - Transmit enable; receive enables win in synchronous
// - Link mode selects synchronous or asynchronous
// - Break request sent, hardware clears on completion
// - Baud speed select only in asynchronous
// - Shift empty status reads one, resets one
// - Transmit ninth bit holds ninth sent bit
// - Two-entry FIFO, third character overruns, stalls
// - Nine-bit receive shows top ninth bit
// - Filter off accepts all; ignored eight-bit
// - Line sampled sixteen times per bit
module async_receiver_address_detect (
  input wire logic clk_sys,
  input wire logic rst_n,
  serial_link_if.device link,
  input wire logic serial_port_enable,
  input wire logic receive_nine_bit_select,
  input wire logic single_receive_enable,
  input wire logic continuous_receive_enable,
  input wire logic address_match_filter_enable,
  input wire logic receive_interrupt_enable,
  input wire logic wide_divisor_select,
  input wire logic [7:0] baud_divisor_high,
  input wire logic [7:0] baud_divisor_low,
  input wire logic receive_data_read,
  input wire logic tx_status_write,
  input wire logic [7:0] tx_status_wdata,
  input wire logic tx_shift_full,
  input wire logic tx_break_done,
  output logic [7:0] receive_status_register,
  output logic [7:0] receive_data_register,
  output logic receive_pending_flag,
  output logic receive_interrupt,
  output logic receive_idle,
  output logic [7:0] transmit_status_register,
  output logic tx_nine_bit,
  output logic tx_enable_active,
  output logic tx_clock_master,
  output logic tx_break_pending
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic line_meta_q, line_q; // Two-stage line synchroniser
  logic [15:0] div_cnt_q; // Baud divisor counter
  logic [2:0] pre_cnt_q; // Prescaler below the divisor
  logic tick_q; // Sixteen-times-bit-rate strobe
  logic [2:0] maj_q; // Last three line samples
  addr_rx_pkg::rx_state_type state_q; // Receive sequence
  logic [3:0] tick_cnt_q; // Ticks within a bit
  logic [3:0] bit_cnt_q; // Data bits received
  logic [8:0] shift_q; // Receive shift register
  addr_rx_pkg::rx_entry_type fifo_q [2]; // Character storage
  logic wr_ptr_q, rd_ptr_q; // FIFO pointers
  logic [1:0] count_q; // Characters held
  logic overrun_q; // Overrun latched
  logic [7:0] txs_q; // Transmit status storage
  logic rx_on; // Receiver running
  logic maj_bit; // Majority of three samples
  logic char_done; // Stop bit sampled this tick
  logic char_keep; // Character passes the filter
  logic push, pop; // FIFO moves
  logic [15:0] divisor; // Divisor in force
  logic [2:0] prescale; // Prescale in force
  addr_rx_pkg::rx_entry_type top; // Oldest unread entry

  // Receiver runs only when enabled and not stalled by overrun
  assign rx_on = serial_port_enable && continuous_receive_enable &&
                 !overrun_q;
  assign maj_bit = (maj_q[0] & maj_q[1]) | (maj_q[1] & maj_q[2]) |
                   (maj_q[0] & maj_q[2]);
  assign char_done = tick_q && (state_q == addr_rx_pkg::RX_STOP) &&
                     (tick_cnt_q == `LAST_TICK);
  // Filter acts only in nine-bit mode
  assign char_keep = !(receive_nine_bit_select &&
                       address_match_filter_enable) || shift_q[8];
  assign push = char_done && char_keep && (count_q != `FIFO_DEPTH);
  assign pop = receive_data_read && (count_q != 2'h0);
  assign top = fifo_q[rd_ptr_q];
  // Eight-bit divisor unless wide divisor selected
  assign divisor = wide_divisor_select ?
                   {baud_divisor_high, baud_divisor_low} :
                   {8'h00, baud_divisor_low};
  // Speed bit only matters in asynchronous mode
  assign prescale = (txs_q[`TXS_HIGH_SPEED] && !txs_q[`TXS_SYNC_MODE]) ||
                    wide_divisor_select ? `PRESCALE_FAST : `PRESCALE_SLOW;

  // ----------------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------------
  // Two flops before any logic looks at the line
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      line_meta_q <= 1'b1;
      line_q <= 1'b1;
    end else begin
      line_meta_q <= link.serial_line;
      line_q <= line_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------------
  // Produces one tick per sixteenth of a bit
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !serial_port_enable) begin
      div_cnt_q <= 16'h0000;
      pre_cnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (pre_cnt_q + 3'h1 >= prescale) begin
        pre_cnt_q <= 3'h0;
        if (div_cnt_q >= divisor) begin
          div_cnt_q <= 16'h0000;
          tick_q <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 16'h0001;
        end
      end else begin
        pre_cnt_q <= pre_cnt_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive sequencer
  // ----------------------------------------------------------------------
  // Start check at half bit, majority sample at each bit centre
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !rx_on) begin
      state_q <= addr_rx_pkg::RX_IDLE;
      tick_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 9'h000;
      maj_q <= 3'h7;
    end else if (tick_q) begin
      maj_q <= {maj_q[1:0], line_q};
      tick_cnt_q <= tick_cnt_q + 4'h1;
      case (state_q)
        addr_rx_pkg::RX_IDLE: begin
          tick_cnt_q <= 4'h0;
          // Low line at a tick starts a character
          if (!line_q) begin
            state_q <= addr_rx_pkg::RX_START;
          end
        end
        addr_rx_pkg::RX_START: begin
          if (tick_cnt_q == `HALF_BIT - 5'h01) begin
            tick_cnt_q <= 4'h0;
            bit_cnt_q <= 4'h0;
            shift_q <= 9'h000;
            // Start bit gone high: abort quietly
            if (line_q) begin
              state_q <= addr_rx_pkg::RX_IDLE;
            end else begin
              state_q <= addr_rx_pkg::RX_DATA;
            end
          end
        end
        addr_rx_pkg::RX_DATA: begin
          if (tick_cnt_q == `LAST_TICK) begin
            // Shift in LSB first; nine bits when selected
            if (receive_nine_bit_select) begin
              shift_q <= {maj_bit, shift_q[8:1]};
            end else begin
              shift_q <= {1'b0, maj_bit, shift_q[7:1]};
            end
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q + 4'h1 == (receive_nine_bit_select ?
                `BITS_NINE : `BITS_EIGHT)) begin
              state_q <= addr_rx_pkg::RX_STOP;
            end
          end
        end
        addr_rx_pkg::RX_STOP: begin
          // Stop bit sampled; filter state read here
          if (tick_cnt_q == `LAST_TICK) begin
            state_q <= addr_rx_pkg::RX_IDLE;
          end
        end
        default: state_q <= addr_rx_pkg::RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------------
  // Two entries; port disable empties it
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !serial_port_enable) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
    end else begin
      if (push) begin
        // Framing error kept per character
        fifo_q[wr_ptr_q] <= '{frame_err: !maj_bit, data: shift_q};
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------------
  // Overrun
  // ----------------------------------------------------------------------
  // Third kept character with full FIFO; cleared by receive disable
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !serial_port_enable || !continuous_receive_enable) begin
      overrun_q <= 1'b0;
    end else if (char_done && char_keep && count_q == `FIFO_DEPTH) begin
      overrun_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit status register
  // ----------------------------------------------------------------------
  // Software write; hardware break clear wins over a write
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !serial_port_enable) begin
      txs_q <= `TXS_RESET;
    end else begin
      if (tx_status_write) begin
        txs_q <= tx_status_wdata;
      end
      if (tx_break_done && !txs_q[`TXS_SYNC_MODE]) begin
        txs_q[`TXS_BREAK_REQ] <= 1'b0;
      end
      txs_q[`TXS_SHIFT_EMPTY] <= !tx_shift_full;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  // Status views follow the storage one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      receive_status_register <= 8'h00;
      receive_data_register <= 8'h00;
      receive_pending_flag <= 1'b0;
      receive_interrupt <= 1'b0;
      receive_idle <= 1'b1;
      transmit_status_register <= `TXS_RESET;
      tx_nine_bit <= 1'b0;
      tx_enable_active <= 1'b0;
      tx_clock_master <= 1'b0;
      tx_break_pending <= 1'b0;
    end else begin
      receive_status_register <= {serial_port_enable,
        receive_nine_bit_select, single_receive_enable,
        continuous_receive_enable, address_match_filter_enable,
        (count_q != 2'h0) && top.frame_err, overrun_q,
        (count_q != 2'h0) && top.data[8]};
      receive_data_register <= top.data[7:0];
      // Pending while enabled with an unread character
      receive_pending_flag <= serial_port_enable && (count_q != 2'h0);
      receive_interrupt <= serial_port_enable && (count_q != 2'h0) &&
                           receive_interrupt_enable;
      receive_idle <= (state_q == addr_rx_pkg::RX_IDLE);
      transmit_status_register <= txs_q;
      tx_nine_bit <= txs_q[`TXS_NINE_SEL];
      // Receive enables override transmit in synchronous
      tx_enable_active <= serial_port_enable && txs_q[`TXS_TX_EN] &&
        !(txs_q[`TXS_SYNC_MODE] &&
          (single_receive_enable || continuous_receive_enable));
      tx_clock_master <= txs_q[`TXS_SYNC_MODE] &&
                         txs_q[`TXS_CLK_SRC];
      tx_break_pending <= txs_q[`TXS_BREAK_REQ] &&
                          !txs_q[`TXS_SYNC_MODE];
    end
  end

endmodule // async_receiver_address_detect

// ### tb/async_receiver_address_detect_asserts.sv
/*
  Holds the concurrent checks on the link and the receiver outputs.
  Assumes the bench instantiates it beside the serial link interface.
*/
`timescale 1ns/1ps
`include "addr_rx_defs.svh"
module async_receiver_address_detect_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serial_line,
  input wire logic tx_ready,
  input wire logic serial_port_enable,
  input wire logic continuous_receive_enable,
  input wire logic receive_interrupt_enable,
  input wire logic tx_shift_full,
  input wire logic tx_break_done,
  input wire logic [7:0] receive_status_register,
  input wire logic receive_pending_flag,
  input wire logic receive_interrupt,
  input wire logic [7:0] transmit_status_register,
  input wire logic tx_nine_bit,
  input wire logic tx_enable_active,
  input wire logic tx_clock_master,
  input wire logic tx_break_pending
);
  // ----------------------------------------------------------------
  // Shared clocking
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  irq_needs_pend_a: assert property (
    receive_interrupt |-> receive_pending_flag) else $error("irq alone");
  irq_masked_a: assert property (
    !receive_interrupt_enable [*2] |-> !receive_interrupt)
    else $error("irq while masked");
  port_off_a: assert property (
    !serial_port_enable [*2] |-> !receive_pending_flag)
    else $error("pending while port off");
  overrun_clear_a: assert property (
    !continuous_receive_enable [*3]
    |-> !receive_status_register[`RXS_OVERRUN]) else $error("overrun kept");
  ninth_set_a: assert property (
    receive_pending_flag && receive_status_register[`RXS_NINE_SEL] &&
    receive_status_register[`RXS_ADDR_EN] |-> receive_status_register[0])
    else $error("filtered char ninth low");
  start_low_a: assert property (
    tx_ready |-> !serial_line) else $error("no start bit");

  // ----------------------------------------------------------------
  // Transmit status
  // ----------------------------------------------------------------
  shift_full_a: assert property (
    (serial_port_enable && tx_shift_full) [*3]
    |-> !transmit_status_register[1]) else $error("empty while full");
  shift_empty_a: assert property (
    !tx_shift_full [*3] |-> transmit_status_register[1])
    else $error("full while empty");
  break_clear_a: assert property (
    tx_break_done |-> ##2 !tx_break_pending) else $error("break kept");
  break_view_a: assert property (
    tx_break_pending |-> transmit_status_register[3] &&
    !transmit_status_register[4]) else $error("break view wrong");
  clk_master_a: assert property (
    tx_clock_master == (transmit_status_register[7] &&
    transmit_status_register[4])) else $error("master wrong");
  nine_view_a: assert property (
    tx_nine_bit == transmit_status_register[6]) else $error("width wrong");
  tx_en_view_a: assert property (
    tx_enable_active |-> transmit_status_register[5])
    else $error("tx enable wrong");
endmodule // async_receiver_address_detect_asserts

// ### tb/test_async_receiver_address_detect.sv
/*
  Holds the bench: remote transmitter facing the receiver over the link.
  Assumes the defs header and link interface are compiled first.
*/
`timescale 1ns/1ps
`include "addr_rx_defs.svh"
module test_async_receiver_address_detect;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0; // System clock
  logic rst_n = 1'b0; // Sync reset
  logic port_en, nine_sel, single_en, cont_en, filt_en, rie; // Controls
  logic rd, txw, shift_full, brk_done, tx_valid, tx_nine; // Strobes
  logic [7:0] txwd, rx_stat, rx_data, tx_stat; // Register values
  logic [8:0] tx_data, v, d; // Characters
  logic pend, irq, idle, t9, ten, tcm, tbp, tx_ready; // Outputs
  logic auto_read; // Monitor may pop
  logic wide; // Wide divisor select
  logic [8:0] q[$]; // Expected characters
  integer errors, checked, seed, i; // Counters
  serial_link_if serial_link_if_inst ();

  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Both ends and checker
  // ----------------------------------------------------------------
  remote_async_transmitter remote_async_transmitter_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(serial_link_if_inst),
    .tx_valid(tx_valid), .tx_data(tx_data), .nine_bit(tx_nine),
    .bit_cycles(16'h0020), .tx_ready(tx_ready));
  async_receiver_address_detect async_receiver_address_detect_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(serial_link_if_inst),
    .serial_port_enable(port_en), .receive_nine_bit_select(nine_sel),
    .single_receive_enable(single_en),
    .continuous_receive_enable(cont_en),
    .address_match_filter_enable(filt_en),
    .receive_interrupt_enable(rie), .wide_divisor_select(wide),
    .baud_divisor_high(8'h00), .baud_divisor_low(8'h01),
    .receive_data_read(rd), .tx_status_write(txw),
    .tx_status_wdata(txwd), .tx_shift_full(shift_full),
    .tx_break_done(brk_done), .receive_status_register(rx_stat),
    .receive_data_register(rx_data), .receive_pending_flag(pend),
    .receive_interrupt(irq), .receive_idle(idle),
    .transmit_status_register(tx_stat), .tx_nine_bit(t9),
    .tx_enable_active(ten), .tx_clock_master(tcm),
    .tx_break_pending(tbp));
  async_receiver_address_detect_asserts checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .serial_line(serial_link_if_inst.serial_line), .tx_ready(tx_ready),
    .serial_port_enable(port_en), .continuous_receive_enable(cont_en),
    .receive_interrupt_enable(rie), .tx_shift_full(shift_full),
    .tx_break_done(brk_done), .receive_status_register(rx_stat),
    .receive_pending_flag(pend), .receive_interrupt(irq),
    .transmit_status_register(tx_stat), .tx_nine_bit(t9),
    .tx_enable_active(ten), .tx_clock_master(tcm),
    .tx_break_pending(tbp));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input string name, input logic [8:0] seen,
    input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hand one character to the remote end, note it if it must arrive
  task send(input logic [8:0] c, input logic keep);
    integer n;
    @(negedge clk_sys);
    tx_valid = 1'b1;
    tx_data = c;
    tx_nine = nine_sel;
    if (keep) q.push_back(c);
    n = 0;
    while (tx_ready !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 2000) begin errors++; finish_test(); end
    end
    tx_valid = 1'b0;
  endtask

  // Wait for the receiver to go idle and, when auto_read is set, the notes to be used up
  task drain(input string name);
    integer n;
    repeat (40) @(negedge clk_sys);
    n = 0;
    while (!(idle === 1'b1 &&
      (!auto_read || (q.size() == 0 && pend === 1'b0)))) begin
      @(negedge clk_sys);
      n++;
      if (n > 4000) begin errors++; finish_test(); end
    end
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // Monitor: pops a note per delivered character
  // ----------------------------------------------------------------
  initial begin
    rd = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (auto_read && pend === 1'b1) begin
        @(negedge clk_sys);
        if (q.size() == 0) begin
          errors++;
          $display("[ERR] char exp none seen %h", rx_data);
        end else begin
          d = q.pop_front();
          check("data", {1'b0, rx_data}, {1'b0, d[7:0]});
          check("ninth", rx_stat[`RXS_NINTH], d[8]);
          check("framing_error_flag", rx_stat[`RXS_FRAME_ERR], 1'b0);
          check("irq", irq, rie);
        end
        rd = 1'b1;
        @(negedge clk_sys);
        rd = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 11;
    errors = 0;
    checked = 0;
    auto_read = 1'b1;
    {port_en, nine_sel, single_en, cont_en, filt_en, rie} = 6'h00;
    {txw, shift_full, brk_done, tx_valid, tx_nine} = 5'h00;
    txwd = 8'h00;
    wide = 1'b1;
    tx_data = 9'h000;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("txstat", tx_stat, `TXS_RESET);
    check("idle", idle, 1'b1);
    port_en = 1'b1;
    @(negedge clk_sys);
    rie = 1'b1;
    filt_en = 1'b1;
    @(negedge clk_sys);
    cont_en = 1'b1;
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      v[8] = 1'b0;
      send(v, 1'b1);
    end
    drain("eight_bit");
    nine_sel = 1'b1;
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      v[8] = i[0];
      send(v, v[8]);
    end
    drain("filter");
    send(9'h1A5, 1'b1);
    drain("address");
    filt_en = 1'b0;
    for (i = 0; i < 2; i++) begin
      v = $random(seed);
      v[8] = 1'b0;
      send(v, 1'b1);
    end
    drain("message");
    filt_en = 1'b1;
    send(9'h033, 1'b0);
    drain("refilter");
    // Narrow divisor, high-speed async: same bit time only if honoured
    wide = 1'b0;
    txwd = 8'h04;
    txw = 1'b1;
    @(negedge clk_sys);
    txw = 1'b0;
    rie = 1'b0;
    send(9'h1C3, 1'b1);
    drain("masked");
    rie = 1'b1;
    filt_en = 1'b0;
    auto_read = 1'b0;
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      send(v, i < 2);
    end
    drain("fill");
    check("overrun", rx_stat[`RXS_OVERRUN], 1'b1);
    check("pending", pend, 1'b1);
    cont_en = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("ovr_clear", rx_stat[`RXS_OVERRUN], 1'b0);
    auto_read = 1'b1;
    drain("overrun");
    cont_en = 1'b1;
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      v[4] = i[0];
      shift_full = v[8];
      single_en = i[1];
      txwd = v[7:0];
      txw = 1'b1;
      @(negedge clk_sys);
      txw = 1'b0;
      repeat (3) @(negedge clk_sys);
      check("txstat", tx_stat, {v[7:2], ~v[8], v[0]});
      check("transmit_enable_bit", ten, v[5] & ~(v[4] & (single_en | cont_en)));
      check("master", tcm, v[7] & v[4]);
      check("nine", t9, v[6]);
      check("break", tbp, v[3] & ~v[4]);
      brk_done = 1'b1;
      @(negedge clk_sys);
      brk_done = 1'b0;
      repeat (2) @(negedge clk_sys);
      check("brk_clr", tbp, 1'b0);
    end
    $display("test tx_status done");
    finish_test();
  end
endmodule // test_async_receiver_address_detect
